// file: host_identify_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_identify_model (
  input  wire logic        clk,       // core clock
  input  wire logic        reset_n,   // async reset, active low
  output var  logic        wordReq,   // identify word request
  output var  logic [7:0]  wordIndex, // requested word number
  input  wire logic [15:0] wordData,  // returned word
  input  wire logic        wordValid  // answer strobe
);
  initial begin
    wordReq   = 1'b0;
    wordIndex = 8'h00;
  end

  // ==========================================================================
  // one request, index scrambled once taken
  task fetch(input logic [7:0] idx, output logic [15:0] data);
    while (reset_n !== 1'b1) @(posedge clk);
    @(posedge clk);
    wordReq   <= 1'b1;
    wordIndex <= idx;
    @(posedge clk);
    wordReq   <= 1'b0;
    wordIndex <= ~idx;
    do begin
      @(posedge clk);
    end while (wordValid !== 1'b1);
    data = wordData;
  endtask : fetch
endmodule : host_identify_model

`default_nettype wire

// file: identify_consts.svh
`ifndef IDENTIFY_CONSTS_SVH
`define IDENTIFY_CONSTS_SVH

// ==========================================================================
// register byte offsets
`define OFS_RSTRES   8'h00
`define OFS_ACOUSTIC 8'h04
`define OFS_SECTOR   8'h08
`define OFS_CAPLO    8'h0c
`define OFS_CAPHI    8'h10
`define OFS_WWNHI    8'h14
`define OFS_WWNLO    8'h18
`define OFS_FEAT     8'h1c
`define OFS_POWER    8'h20
`define OFS_CACHE    8'h24
`define OFS_STATUS   8'h28

// ==========================================================================
// register count, writable masks and reset values
`define NUM_CFG_REGS 10
`define MASK_RSTRES   32'h0000_00ff
`define MASK_ACOUSTIC 32'h0000_ffff
`define MASK_SECTOR   32'h3fff_003f
`define MASK_CAPLO    32'hffff_ffff
`define MASK_CAPHI    32'h0000_ffff
`define MASK_WWNHI    32'hffff_ffff
`define MASK_WWNLO    32'hffff_ffff
`define MASK_FEAT     32'h007f_ff1f
`define MASK_POWER    32'h0f3f_bfff
`define MASK_CACHE    32'h01ff_03ff
`define RST_ZERO      32'h0000_0000
`define RST_CACHE     32'h0101_0000

// ==========================================================================
// identify word numbers
`define W_RESET   8'h5d
`define W_ACOUST  8'h5e
`define W_CAP0    8'h64
`define W_CAP1    8'h65
`define W_CAP2    8'h66
`define W_CAP3    8'h67
`define W_SECTOR  8'h6a
`define W_WWN0    8'h6c
`define W_WWN1    8'h6d
`define W_WWN2    8'h6e
`define W_WWN3    8'h6f
`define W_SUPP    8'h77
`define W_ENAB    8'h78
`define W_SECUR   8'h80
`define W_POWER   8'ha0
`define W_CMDXP   8'hce
`define W_ALIGN   8'hd1
`define W_CACHE   8'hd6
`define W_WRV     8'hdc
`define W_TRANS   8'hde

// ==========================================================================
// field values
`define TRANSPORT_SERIAL 4'h1

`endif

// file: identify_pkg.sv
`default_nettype none

package identify_pkg;

  // reset outcome seen by the master unit
  typedef struct packed {
    logic       cableAbove;
    logic [1:0] numMethod;
    logic       diagPassed;
    logic       sawPassedDiag;
    logic       sawSlavePresent;
    logic       masterResponds;
    logic       isSlave;
  } resetCfg_type;

  // sector geometry fields
  typedef struct packed {
    logic [13:0] alignOffset;
    logic        largeLogical;
    logic        multiLogical;
    logic [3:0]  ratioLog2;
  } sectorCfg_type;

  typedef enum {PH_IDLE, PH_DONE} apbPhase_type;

endpackage : identify_pkg

`default_nettype wire

// file: identify_word_builder.sv
// Functional notes
// - slave unit returns zero in the whole reset result low byte
// - bit 6: master responds while slave selected
// - bit 5: master saw slave-present activity signal
// - bit 4: master saw passed-diagnostics signal
// - bit 3: master self-diagnostic passed
// - bits 2:1: device number method, 01 jumper, 10 cable select, 11 other
// - bit 8 fixed one, bit 0 one for master unit only, bit 7 reserved
// - word 94: recommended acoustic value high, current value low
// - word 106: bit15 zero, bit14 one, bit13 multi, bits 3:0 ratio
// - word 106 bit 12 large logical sector, bits 11:4 reserved
// - words 100-103 hold 48-bit user sector count
// - words 108-111 world wide name, 112-115 reserved
// - word 119 supported feature bits 4 to 1
// - word 120 mirrors 119, bit 1 enabled, bit15 zero, bit14 one
// - word 128 bit 8 security level, other high bits reserved
// - word 128 bits 5:0 security flags, active high
// - word 160 valid, power mode one required, disabled, max current
// - word 206 command transport support bits 5:0, vendor bits 15:12
// - word 209 bit15 zero, bit14 one, bits 13:0 alignment offset
// - word 214 cache versions and enable flags
// - word 220 low byte write-read-verify mode, high byte reserved
// - word 222 transport type in bits 15:12; zero means no version
// - serial transport minor compliance flags in word 222 bits 3:0
`timescale 1ns/1ps
`default_nettype none
`include "identify_consts.svh"

module identify_word_builder (
  input  wire logic        clk,       // 40 MHz core clock
  input  wire logic        reset_n,   // async reset, active low
  input  wire logic        psel,      // apb select
  input  wire logic        penable,   // apb enable
  input  wire logic        pwrite,    // apb direction
  input  wire logic [7:0]  paddr,     // apb byte address
  input  wire logic [31:0] pwdata,    // apb write data
  input  wire logic [3:0]  pstrb,     // apb byte strobes
  output logic      [31:0] prdata,    // apb read data
  output logic             pready,    // apb ready
  output logic             pslverr,   // apb error on unmapped address
  input  wire logic        wordReq,   // identify word request pulse
  input  wire logic [7:0]  wordIndex, // identify word number
  output logic      [15:0] wordData,  // identify word value
  output logic             wordValid  // one-cycle answer strobe
);

  // ========================================================================
  // helpers
  function automatic logic [3:0] regIndex(input logic [7:0] addr);
    regIndex = addr[5:2];
  endfunction : regIndex

  function automatic logic [31:0] regMask(input logic [3:0] idx);
    case (idx)
      4'h0:    regMask = `MASK_RSTRES;
      4'h1:    regMask = `MASK_ACOUSTIC;
      4'h2:    regMask = `MASK_SECTOR;
      4'h3:    regMask = `MASK_CAPLO;
      4'h4:    regMask = `MASK_CAPHI;
      4'h5:    regMask = `MASK_WWNHI;
      4'h6:    regMask = `MASK_WWNLO;
      4'h7:    regMask = `MASK_FEAT;
      4'h8:    regMask = `MASK_POWER;
      4'h9:    regMask = `MASK_CACHE;
      default: regMask = 32'h0000_0000;
    endcase
  endfunction : regMask

  function automatic logic [31:0] regReset(input logic [3:0] idx);
    regReset = (idx == regIndex(`OFS_CACHE)) ? `RST_CACHE : `RST_ZERO;
  endfunction : regReset

  // ========================================================================
  // apb register file
  identify_pkg::apbPhase_type phase_r;
  identify_pkg::apbPhase_type phase_nxt;
  logic [31:0]                cfg_r   [0:`NUM_CFG_REGS-1];
  logic [31:0]                cfg_nxt [0:`NUM_CFG_REGS-1];
  logic [31:0]                prdata_r;
  logic [31:0]                prdata_nxt;
  logic                       pready_r;
  logic                       pready_nxt;
  logic                       pslverr_r;
  logic                       pslverr_nxt;
  logic                       mapped;
  logic                       isStatus;
  logic [3:0]                 idx;
  logic [31:0]                statusWord;
  logic [31:0]                merged;

  assign idx      = regIndex(paddr);
  assign isStatus = (paddr == `OFS_STATUS);
  assign mapped   = (paddr[1:0] == 2'b00) &&
                    ((idx < 4'(`NUM_CFG_REGS)) || isStatus) &&
                    (paddr[7:6] == 2'b00);

  always_comb begin
    phase_nxt   = phase_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    merged      = 32'h0000_0000;
    for (int i = 0; i < `NUM_CFG_REGS; i++) begin
      cfg_nxt[i] = cfg_r[i];
    end
    case (phase_r)
      identify_pkg::PH_IDLE: begin
        if (psel && penable) begin
          phase_nxt   = identify_pkg::PH_DONE;
          pready_nxt  = 1'b1;
          pslverr_nxt = !mapped;
          prdata_nxt  = 32'h0000_0000;
          if (mapped && !pwrite) begin
            prdata_nxt = isStatus ? statusWord : cfg_r[idx];
          end
        end
      end
      identify_pkg::PH_DONE: begin
        // the transfer completes at this edge; writes land here only
        phase_nxt = identify_pkg::PH_IDLE;
        if (psel && penable && pwrite && mapped && !isStatus) begin
          for (int b = 0; b < 4; b++) begin
            merged[b*8 +: 8] = pstrb[b] ? pwdata[b*8 +: 8] : cfg_r[idx][b*8 +: 8];
          end
          cfg_nxt[idx] = merged & regMask(idx);
        end
      end
      default: phase_nxt = identify_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_r   <= identify_pkg::PH_IDLE;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      for (int i = 0; i < `NUM_CFG_REGS; i++) begin
        cfg_r[i] <= regReset(4'(i));
      end
    end else begin
      phase_r   <= phase_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      for (int i = 0; i < `NUM_CFG_REGS; i++) begin
        cfg_r[i] <= cfg_nxt[i];
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ========================================================================
  // configuration fields
  identify_pkg::resetCfg_type  resetCfg;
  identify_pkg::sectorCfg_type sectorCfg;
  logic [15:0]                 word93;
  logic [15:0]                 word106;
  logic [15:0]                 word209;
  logic [31:0]                 acoustReg;
  logic [31:0]                 capLo;
  logic [31:0]                 capHi;
  logic [31:0]                 wwnHi;
  logic [31:0]                 wwnLo;
  logic [31:0]                 featReg;
  logic [31:0]                 powerReg;
  logic [31:0]                 cacheReg;

  assign resetCfg  = identify_pkg::resetCfg_type'(cfg_r[regIndex(`OFS_RSTRES)][7:0]);
  assign sectorCfg = identify_pkg::sectorCfg_type'({cfg_r[regIndex(`OFS_SECTOR)][29:16],
                                                    cfg_r[regIndex(`OFS_SECTOR)][5:0]});
  assign acoustReg = cfg_r[regIndex(`OFS_ACOUSTIC)];
  assign capLo     = cfg_r[regIndex(`OFS_CAPLO)];
  assign capHi     = cfg_r[regIndex(`OFS_CAPHI)];
  assign wwnHi     = cfg_r[regIndex(`OFS_WWNHI)];
  assign wwnLo     = cfg_r[regIndex(`OFS_WWNLO)];
  assign featReg   = cfg_r[regIndex(`OFS_FEAT)];
  assign powerReg  = cfg_r[regIndex(`OFS_POWER)];
  assign cacheReg  = cfg_r[regIndex(`OFS_CACHE)];

  reset_result_encoder resetEnc (
    .cfg    (resetCfg),
    .word93 (word93)
  );

  sector_geometry_encoder sectorEnc (
    .cfg     (sectorCfg),
    .word106 (word106),
    .word209 (word209)
  );

  // ========================================================================
  // identify word assembly
  logic [15:0] wordData_r;
  logic [15:0] wordData_nxt;
  logic        wordValid_r;
  logic        wordValid_nxt;
  logic [7:0]  lastIndex_r;
  logic [7:0]  lastIndex_nxt;
  logic [15:0] served_r;
  logic [15:0] served_nxt;
  logic [15:0] word;
  logic [3:0]  transType;

  assign transType  = cacheReg[19:16];
  assign statusWord = {8'h00, served_r, lastIndex_r};

  // ========================================================================
  // named fields of the configuration words
  logic [7:0]  acoustRecommended;
  logic [7:0]  acoustCurrent;
  logic [3:0]  featSupported;
  logic        wrvEnabled;
  logic [7:0]  wrvMode;
  logic        securityMax;
  logic [5:0]  securityFlags;
  logic        powerValid;
  logic        powerRequired;
  logic        powerDisabled;
  logic [11:0] maxCurrent;
  logic [5:0]  transportBits;
  logic [3:0]  vendorBits;
  logic [3:0]  cacheVersion;
  logic [3:0]  cachePowerVersion;
  logic        cacheEnabled;
  logic        cachePowerEnabled;
  logic [3:0]  minorBits;
  logic        reportVersion;

  // security and verify-mode fields share the feature word
  assign acoustRecommended = acoustReg[15:8];
  assign acoustCurrent     = acoustReg[7:0];
  assign featSupported     = featReg[3:0];
  assign wrvEnabled        = featReg[4];
  assign wrvMode           = featReg[15:8];
  assign securityMax       = featReg[16];
  assign securityFlags     = featReg[22:17];
  assign powerValid        = powerReg[15];
  assign powerRequired     = powerReg[13];
  assign powerDisabled     = powerReg[12];
  assign maxCurrent        = powerReg[11:0];
  assign transportBits     = powerReg[21:16];
  assign vendorBits        = powerReg[27:24];
  assign cacheVersion      = cacheReg[3:0];
  assign cachePowerVersion = cacheReg[7:4];
  assign cacheEnabled      = cacheReg[8];
  assign cachePowerEnabled = cacheReg[9];
  assign minorBits         = cacheReg[23:20];
  assign reportVersion     = cacheReg[24];

  always_comb begin
    word = 16'h0000;
    case (wordIndex)
      `W_RESET:  word = word93;
      `W_ACOUST: word = {acoustRecommended, acoustCurrent};
      `W_CAP0:   word = capLo[15:0];
      `W_CAP1:   word = capLo[31:16];
      `W_CAP2:   word = capHi[15:0];
      `W_CAP3:   word = 16'h0000;
      `W_SECTOR: word = word106;
      `W_WWN0:   word = wwnHi[31:16];
      `W_WWN1:   word = wwnHi[15:0];
      `W_WWN2:   word = wwnLo[31:16];
      `W_WWN3:   word = wwnLo[15:0];
      `W_SUPP: begin
        word[15:14] = 2'b01;
        word[4:1]   = featSupported;
      end
      `W_ENAB: begin
        word[15:14] = 2'b01;
        word[4:2]   = featSupported[3:1];
        word[1]     = wrvEnabled;
      end
      `W_SECUR: begin
        word[8]   = securityMax;
        word[5:0] = securityFlags;
      end
      `W_POWER: begin
        word[15]   = powerValid;
        word[13]   = powerRequired;
        word[12]   = powerDisabled;
        word[11:0] = maxCurrent;
      end
      `W_CMDXP: begin
        word[15:12] = vendorBits;
        word[5:0]   = transportBits;
      end
      `W_ALIGN:  word = word209;
      `W_CACHE: begin
        word[15:12] = cacheVersion;
        word[11:8]  = cachePowerVersion;
        word[4]     = cacheEnabled;
        word[0]     = cachePowerEnabled;
      end
      `W_WRV:    word = {8'h00, wrvMode};
      `W_TRANS: begin
        if (reportVersion) begin
          word[15:12] = transType;
          if (transType == `TRANSPORT_SERIAL) begin
            word[3:0] = minorBits;
          end
        end
      end
      default:   word = 16'h0000;
    endcase
  end

  always_comb begin
    wordData_nxt  = wordData_r;
    wordValid_nxt = 1'b0;
    lastIndex_nxt = lastIndex_r;
    served_nxt    = served_r;
    if (wordReq) begin
      wordData_nxt  = word;
      wordValid_nxt = 1'b1;
      lastIndex_nxt = wordIndex;
      served_nxt    = served_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wordData_r  <= 16'h0000;
      wordValid_r <= 1'b0;
      lastIndex_r <= 8'h00;
      served_r    <= 16'h0000;
    end else begin
      wordData_r  <= wordData_nxt;
      wordValid_r <= wordValid_nxt;
      lastIndex_r <= lastIndex_nxt;
      served_r    <= served_nxt;
    end
  end

  assign wordData  = wordData_r;
  assign wordValid = wordValid_r;

endmodule : identify_word_builder

`default_nettype wire

// file: identify_word_builder_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "identify_consts.svh"

module identify_word_builder_sva (
  input wire logic        clk,       // core clock
  input wire logic        reset_n,   // async reset, active low
  input wire logic        pready,    // apb ready
  input wire logic        pslverr,   // apb error
  input wire logic        wordReq,   // word request
  input wire logic [7:0]  wordIndex, // word number
  input wire logic [15:0] wordData,  // word value
  input wire logic        wordValid  // answer strobe
);
  logic [7:0] lastIdx_r;
  logic [7:0] lastIdx_nxt;
  logic [7:0] ansIdx;

  // ==========================================================================
  // number of the word being answered
  always_comb begin
    lastIdx_nxt = wordReq ? wordIndex : lastIdx_r;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lastIdx_r <= 8'h00;
    end else begin
      lastIdx_r <= lastIdx_nxt;
    end
  end
  assign ansIdx = wordValid ? lastIdx_r : 8'h00;

  // ==========================================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_answer; wordReq |=> wordValid; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_error; pslverr |-> pready; endproperty
  property p_reset;
    ansIdx == `W_RESET |-> wordData[15:14] == 2'b01 && wordData[12:7] == 6'h02
      && (wordData[0] || wordData[7:0] == 8'h00);
  endproperty
  property p_sector;
    ansIdx == `W_SECTOR |-> wordData[15:14] == 2'b01 && wordData[11:4] == 8'h00;
  endproperty
  property p_enab;
    ansIdx == `W_ENAB |-> wordData[15:14] == 2'b01 && wordData[13:5] == 9'h000;
  endproperty
  property p_secur;
    ansIdx == `W_SECUR |-> wordData[15:9] == 7'h00 && wordData[7:6] == 2'b00;
  endproperty
  property p_align; ansIdx == `W_ALIGN |-> wordData[15:14] == 2'b01; endproperty
  property p_wrv; ansIdx == `W_WRV |-> wordData[15:8] == 8'h00; endproperty
  property p_trans;
    ansIdx == `W_TRANS |-> wordData[11:4] == 8'h00
      && (wordData[15:12] == `TRANSPORT_SERIAL || wordData[3:0] == 4'h0);
  endproperty

  a_answer: assert property (p_answer) else $error("word request not answered");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_error: assert property (p_error) else $error("error without ready");
  a_reset: assert property (p_reset) else $error("reset result word wrong");
  a_sector: assert property (p_sector) else $error("sector word fixed bits wrong");
  a_enab: assert property (p_enab) else $error("enabled word fixed bits wrong");
  a_secur: assert property (p_secur) else $error("security reserved bits set");
  a_align: assert property (p_align) else $error("alignment word fixed bits wrong");
  a_wrv: assert property (p_wrv) else $error("verify mode high byte set");
  a_trans: assert property (p_trans) else $error("transport word wrong");

  c_reset: cover property (ansIdx == `W_RESET);
  c_err: cover property (pslverr);
  c_trans: cover property (ansIdx == `W_TRANS && wordData != 16'h0000);
endmodule : identify_word_builder_sva

bind identify_word_builder identify_word_builder_sva identify_word_builder_sva_inst (
  .clk(clk), .reset_n(reset_n), .pready(pready), .pslverr(pslverr), .wordReq(wordReq),
  .wordIndex(wordIndex), .wordData(wordData), .wordValid(wordValid));

`default_nettype wire

// file: reset_result_encoder.sv
`timescale 1ns/1ps
`default_nettype none

module reset_result_encoder (
  input  wire identify_pkg::resetCfg_type cfg,    // reset outcome settings
  output logic [15:0]                     word93  // hardware reset result word
);

  logic [7:0] lowByte;

  always_comb begin
    lowByte = {1'b0,
               cfg.masterResponds,
               cfg.sawSlavePresent,
               cfg.sawPassedDiag,
               cfg.diagPassed,
               cfg.numMethod,
               1'b1};
    if (cfg.isSlave) begin
      lowByte = 8'h00;
    end
    word93 = {1'b0, 1'b1, cfg.cableAbove, 4'h0, 1'b1, lowByte};
  end

endmodule : reset_result_encoder

`default_nettype wire

// file: sector_geometry_encoder.sv
`timescale 1ns/1ps
`default_nettype none

module sector_geometry_encoder (
  input  wire identify_pkg::sectorCfg_type cfg,    // geometry settings
  output logic [15:0]                      word106, // sector size word
  output logic [15:0]                      word209  // alignment word
);

  always_comb begin
    word106 = {1'b0, 1'b1, cfg.multiLogical, cfg.largeLogical,
               8'h00, cfg.ratioLog2};
    word209 = {1'b0, 1'b1, cfg.alignOffset};
  end

endmodule : sector_geometry_encoder

`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "identify_consts.svh"

module testbench;
  logic        clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wordReq;
  logic [7:0]  wordIndex;
  logic [15:0] wordData;
  logic        wordValid;
  logic [31:0] rd;
  logic        er;
  int          mismatches;
  int          nChecks;
  logic [7:0]  rsIn [5] = '{8'hff, 8'h22, 8'h44, 8'h68, 8'h90};
  logic [15:0] rsEx [5] = '{16'h6100, 16'h4143, 16'h4125, 16'h4117, 16'h6109};

  identify_word_builder identify_word_builder_inst (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wordReq(wordReq), .wordIndex(wordIndex), .wordData(wordData),
    .wordValid(wordValid));
  host_identify_model host_identify_model_inst (
    .clk(clk), .reset_n(reset_n), .wordReq(wordReq), .wordIndex(wordIndex),
    .wordData(wordData), .wordValid(wordValid));

  // ==========================================================================
  // tasks
  task wrap_up();
    if (mismatches == 0 && nChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd_chk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), rd, x);
  endtask : rd_chk

  task w_chk(input logic [7:0] i, input logic [15:0] x);
    logic [15:0] d;
    host_identify_model_inst.fetch(i, d);
    check($sformatf("word %0d", i), {16'h0, d}, {16'h0, x});
  endtask : w_chk

  // ==========================================================================
  // clock, watchdog and tests
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #50000;
    mismatches++;
    wrap_up();
  end

  initial begin
    reset_n = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    pstrb   = 4'hf;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(`OFS_CACHE, `RST_CACHE);
    rd_chk(`OFS_RSTRES, `RST_ZERO);
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, `OFS_RSTRES, {24'h0, rsIn[k]});
      w_chk(`W_RESET, rsEx[k]);
    end
    apb(1'b1, `OFS_ACOUSTIC, 32'h0000_a53c);
    w_chk(`W_ACOUST, 16'ha53c);
    pstrb <= 4'h2;
    apb(1'b1, `OFS_ACOUSTIC, 32'h0000_7700);
    pstrb <= 4'hf;
    w_chk(`W_ACOUST, 16'h773c);
    apb(1'b1, `OFS_SECTOR, 32'hffff_ffff);
    rd_chk(`OFS_SECTOR, `MASK_SECTOR);
    w_chk(`W_SECTOR, 16'h700f);
    w_chk(`W_ALIGN, 16'h7fff);
    apb(1'b1, `OFS_CAPLO, 32'h89ab_cdef);
    apb(1'b1, `OFS_CAPHI, 32'h0000_4567);
    w_chk(`W_CAP0, 16'hcdef);
    w_chk(`W_CAP1, 16'h89ab);
    w_chk(`W_CAP2, 16'h4567);
    w_chk(`W_CAP3, 16'h0000);
    apb(1'b1, `OFS_WWNHI, 32'h5123_4567);
    apb(1'b1, `OFS_WWNLO, 32'h89ab_cdef);
    w_chk(`W_WWN0, 16'h5123);
    w_chk(`W_WWN1, 16'h4567);
    w_chk(`W_WWN2, 16'h89ab);
    w_chk(`W_WWN3, 16'hcdef);
    w_chk(8'h70, 16'h0000);
    w_chk(8'h69, 16'h0000);
    apb(1'b1, `OFS_FEAT, 32'h007f_a50f);
    w_chk(`W_SUPP, 16'h401e);
    w_chk(`W_ENAB, 16'h401c);
    w_chk(`W_SECUR, 16'h013f);
    w_chk(`W_WRV, 16'h00a5);
    apb(1'b1, `OFS_FEAT, 32'h0000_0010);
    w_chk(`W_SUPP, 16'h4000);
    w_chk(`W_ENAB, 16'h4002);
    w_chk(`W_SECUR, 16'h0000);
    apb(1'b1, `OFS_POWER, 32'h0f2a_b123);
    w_chk(`W_POWER, 16'hb123);
    w_chk(`W_CMDXP, 16'hf02a);
    apb(1'b1, `OFS_CACHE, 32'h01a1_0365);
    w_chk(`W_CACHE, 16'h5611);
    w_chk(`W_TRANS, 16'h100a);
    apb(1'b1, `OFS_CACHE, 32'h01a0_0000);
    w_chk(`W_TRANS, 16'h0000);
    apb(1'b1, `OFS_CACHE, 32'h00a1_0000);
    w_chk(`W_TRANS, 16'h0000);
    w_chk(8'hff, 16'h0000);
    apb(1'b1, `OFS_STATUS, 32'h0000_0000);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("status index", {24'h0, rd[7:0]}, 32'h0000_00ff);
    check("status count", {16'h0, rd[23:8]}, 32'h0000_0021);
    check("status error", {31'h0, er}, 32'h0);
    rd_chk(8'h2c, 32'h0);
    check("unmapped error", {31'h0, er}, 32'h1);
    rd_chk(8'h02, 32'h0);
    check("misaligned error", {31'h0, er}, 32'h1);
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    check("word after reset", {16'h0, wordData}, 32'h0);
    rd_chk(`OFS_ACOUSTIC, `RST_ZERO);
    rd_chk(`OFS_CACHE, `RST_CACHE);
    w_chk(`W_TRANS, {`TRANSPORT_SERIAL, 12'h000});
    wrap_up();
  end
endmodule : testbench

`default_nettype wire
